// [hw/rtcp_top.sv]
// Output, interrupt, RAM wipe and supply gating logic of the clock device.
//
// Overview of operation
// [R1] Interrupt pin is open drain, active low; released, never driven high.
// [R2] Interrupt pin stays low while any enabled status flag is set.
// [R3] Host clears every enabled set flag to release the interrupt pin.
// [R4] Enabled wipe input held low writes all ones to all 242 RAM bytes.
// [R5] Wipe works whether or not primary supply is present.
// [R6] Supply return sets divider bit and forced 32k bit; output after recovery.
// [R7] Square wave runs when square-wave enable or forced 32k is set.
// [R8] Forced 32k outputs the oscillator regardless of rate and enable.
// [R9] Otherwise frequency is one of 13 divider taps chosen by rate.
// [R10] Forced 32k and square-wave enable each switch the output.
// [R11] Below trip, 32k still runs with forced 32k, aux enable, aux supply.
// [R12] Host reads and writes blocked while primary supply is below trip.
// [R13] Host writes aux enable zero when aux supply is unused.
// [R14] Oscillator runs or stops by a software enable bit.
// [R15] Timebase is a 32.768 kHz signal on the oscillator input pin.
// [R16] Below trip, host inputs ignored and bus outputs released.
// [R17] Interrupt pin released in the same cycle the last enabled flag clears.
//
// The plain strobed port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module rtcp_top (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Supply monitors, asynchronous
    input wire logic vcc_ok,
    input wire logic aux_supply,
    // Pins
    input wire logic osc_in,
    input wire logic ram_wipe_n,
    output logic irq_n_o,
    output logic irq_n_oe,
    output logic square_wave_out,
    // Same-clock events from the counters and alarm logic
    input wire logic ext_event
);
    import rtcp_pkg::*;

    typedef struct packed {
        logic vcc_s1;
        logic vcc_s2;
        logic vcc_prev;
        logic aux_s1;
        logic aux_s2;
        logic wipe_s1;
        logic wipe_s2;
        logic [CA_W-1:0] ctrl_a;
        logic [7:0] ctrl_b;
        logic [EXT_W-1:0] ext;
        logic [STAT_W-1:0] status;
        logic [STAT_W-1:0] mask;
        logic [REC_W-1:0] rec_cnt;
        logic recovering;
        logic [7:0] rd_data;
        logic irq_oe;
        logic irq_low;
        logic sqw;
    } rtcp_core_s;

    rtcp_core_s st;
    rtcp_core_s nx;
    logic bus_ok;
    logic powerup;
    logic powerdown;
    logic sqw_allowed;
    logic [STAT_W-1:0] clr;
    logic [STAT_W-1:0] set;
    logic wave;
    logic div_active;
    logic wipe_done;
    logic wiping;
    logic wipe_req;

    rtcp_ram_if ram_bus();

    ////////////////////////////////////////////////////////////////////////////
    // Supply state.  Access waits one extra cycle past the synchroniser so a
    // write cannot land in the same cycle as the power-up preset.
    assign powerup = st.vcc_s2 && !st.vcc_prev;
    assign powerdown = !st.vcc_s2 && st.vcc_prev;
    assign bus_ok = st.vcc_s2 && st.vcc_prev && !st.recovering; // see [R12] see [R16]

    // The wipe request is not gated by supply, it runs on backup power too.
    // Leave the enable clear on boards that have no switch on the wipe pin.
    assign wipe_req = st.ext[EXT_WIPE_EN_BIT] && !st.wipe_s2; // see [R4] see [R5]

    // Below trip only the forced 32k path survives, and only on aux supply.
    assign sqw_allowed = st.vcc_s2 ? !st.recovering
        : (st.ext[EXT_FORCE_32K_EN_BIT] && st.ext[EXT_ABE_BIT] && st.aux_s2); // see [R11] see [R6]

    // RAM access through the shared path; the window above the registers maps to RAM.
    assign ram_bus.wr = bus_ok && reg_wr && reg_addr >= ADDR_RAM_BASE; // see [R12]
    assign ram_bus.idx = reg_addr - ADDR_RAM_BASE;
    assign ram_bus.wdata = reg_wdata;

    ////////////////////////////////////////////////////////////////////////////
    // All register state moves here.
    always_comb begin
        nx = st;
        clr = '0;
        nx.vcc_s1 = vcc_ok;
        nx.vcc_s2 = st.vcc_s1;
        nx.vcc_prev = st.vcc_s2;
        nx.aux_s1 = aux_supply;
        nx.aux_s2 = st.aux_s1;
        nx.wipe_s1 = ram_wipe_n;
        nx.wipe_s2 = st.wipe_s1;
        nx.rd_data = 8'h00;
        nx.irq_low = 1'b0; // see [R1]

        // A supply loss mid-count does not restart the delay; the next power-up reloads it.
        if (st.recovering) begin
            if (st.rec_cnt == '0) begin
                nx.recovering = 1'b0;
            end else begin
                nx.rec_cnt = st.rec_cnt - 1'b1;
            end
        end

        // Register writes; a blocked cycle leaves every register untouched.
        if (bus_ok && reg_wr) begin // see [R12]
            case (reg_addr)
                ADDR_CTRL_A: nx.ctrl_a = reg_wdata[CA_W-1:0];
                ADDR_CTRL_B: nx.ctrl_b = reg_wdata; // see [R10]
                ADDR_EXT: nx.ext = reg_wdata[EXT_W-1:0]; // see [R10] see [R14]
                ADDR_STAT: clr = reg_wdata[STAT_W-1:0];
                ADDR_MASK: nx.mask = reg_wdata[STAT_W-1:0];
                default: ;
            endcase
        end

        // Register reads; blocked reads and unmapped offsets return zero.
        if (bus_ok && reg_rd) begin // see [R16]
            case (reg_addr)
                ADDR_CTRL_A: nx.rd_data = {div_active, st.ctrl_a};
                ADDR_CTRL_B: nx.rd_data = st.ctrl_b;
                ADDR_EXT: nx.rd_data = {2'b00, wiping, st.aux_s2, st.ext};
                ADDR_STAT: nx.rd_data = {4'h0, st.status};
                ADDR_MASK: nx.rd_data = {4'h0, st.mask};
                default: nx.rd_data = (reg_addr >= ADDR_RAM_BASE) ? ram_bus.rdata : 8'h00;
            endcase
        end

        // Supply return restarts the timebase and the 32k output after the delay.
        if (powerup) begin
            nx.ctrl_a[CA_DV1_BIT] = 1'b1; // see [R6]
            nx.ext[EXT_FORCE_32K_EN_BIT] = 1'b1; // see [R6]
            nx.ext[EXT_OSC_EN_BIT] = 1'b1;
            nx.recovering = 1'b1;
            nx.rec_cnt = REC_W'(REC_CYCLES - 1);
        end

        // Events set the sticky bits; a set in the clearing cycle wins.
        // A flag cleared in the cycle its event repeats therefore stays set.
        set = '0;
        set[ST_WIPE_DONE] = wipe_done;
        set[ST_PWR_FAIL] = powerdown;
        set[ST_PWR_UP] = powerup;
        set[ST_EXT_EVT] = ext_event;
        nx.status = (st.status & ~clr) | set;

        // Built from next state so the pin tracks the flags with no lag.
        // Below trip the pin is released but the flags are kept for after power-up.
        nx.irq_oe = |(nx.status & nx.mask) && nx.vcc_s2; // see [R2] see [R17] see [R16]
        nx.sqw = wave && sqw_allowed; // see [R7] see [R11]
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= nx;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Submodules.
    rtcp_sqw u_sqw (
        .core_clk(core_clk),
        .rst(rst),
        .osc_in(osc_in),
        .osc_en(st.ext[EXT_OSC_EN_BIT]),
        .div_run(st.ctrl_a[CA_DV1_BIT]),
        .force_32k_en(st.ext[EXT_FORCE_32K_EN_BIT]),
        .square_wave_en(st.ctrl_b[CB_SQUARE_WAVE_EN_BIT]),
        .rate(st.ctrl_a[CA_RATE_LSB +: RATE_W]),
        .wave(wave),
        .div_active(div_active)
    );

    rtcp_wipe u_wipe (
        .core_clk(core_clk),
        .rst(rst),
        .bus(ram_bus.ram),
        .wipe_req(wipe_req),
        .wipe_done(wipe_done),
        .wiping(wiping)
    );

    // The pin only ever pulls low; the enable decides whether it is driven.
    assign irq_n_o = st.irq_low; // see [R1]
    assign irq_n_oe = st.irq_oe;
    assign reg_rdata = st.rd_data;
    assign square_wave_out = st.sqw;

    ////////////////////////////////////////////////////////////////////////////
    // Checks.
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence s_powerup;
        powerup;
    endsequence

    sequence s_recover_hold;
        st.recovering [*8];
    endsequence

    property p_irq_low_level;
        irq_n_o == 1'b0;
    endproperty
    a_irq_low_level: assert property (p_irq_low_level) else $error("interrupt pin drives high"); // see [R1]

    property p_irq_pending;
        |(st.status & st.mask) && st.vcc_s2 |-> irq_n_oe;
    endproperty
    a_irq_pending: assert property (p_irq_pending) else $error("enabled flag set but pin released"); // see [R2]

    property p_irq_release;
        reg_wr && bus_ok && reg_addr == ADDR_STAT && (reg_wdata[STAT_W-1:0] & st.mask) == st.mask
            && set == '0 |=> !irq_n_oe;
    endproperty
    a_irq_release: assert property (p_irq_release) else $error("pin not released after flags cleared"); // see [R17]

    property p_block_write;
        !bus_ok && reg_wr && reg_addr == ADDR_MASK |=> $stable(st.mask);
    endproperty
    a_block_write: assert property (p_block_write) else $error("write taken while access blocked"); // see [R12]

    property p_block_read;
        !bus_ok && reg_rd |=> reg_rdata == 8'h00;
    endproperty
    a_block_read: assert property (p_block_read) else $error("read answered while access blocked"); // see [R16]

    property p_powerup_bits;
        s_powerup |=> st.ctrl_a[CA_DV1_BIT] && st.ext[EXT_FORCE_32K_EN_BIT] ##0 s_recover_hold;
    endproperty
    a_powerup_bits: assert property (p_powerup_bits) else $error("power-up preset or delay wrong"); // see [R6]

    property p_quiet_in_recovery;
        st.recovering && st.vcc_s2 |=> !square_wave_out;
    endproperty
    a_quiet_in_recovery: assert property (p_quiet_in_recovery) else $error("output during recovery"); // see [R6]

    property p_trip_gate;
        !st.vcc_s2 && !(st.ext[EXT_FORCE_32K_EN_BIT] && st.ext[EXT_ABE_BIT] && st.aux_s2) |=> !square_wave_out;
    endproperty
    a_trip_gate: assert property (p_trip_gate) else $error("output below trip without aux 32k"); // see [R11]

    property p_off_when_disabled;
        !st.ext[EXT_FORCE_32K_EN_BIT] && !st.ctrl_b[CB_SQUARE_WAVE_EN_BIT] ##1 !st.ext[EXT_FORCE_32K_EN_BIT] && !st.ctrl_b[CB_SQUARE_WAVE_EN_BIT]
            |=> !square_wave_out;
    endproperty
    a_off_when_disabled: assert property (p_off_when_disabled) else $error("output with both enables off"); // see [R7]

    // Register access checks.
    property p_mask_write;
        bus_ok && reg_wr && reg_addr == ADDR_MASK |=> st.mask == $past(reg_wdata[STAT_W-1:0]);
    endproperty
    a_mask_write: assert property (p_mask_write) else $error("mask write lost while access allowed"); // see [R12]

    property p_ext_write;
        bus_ok && reg_wr && reg_addr == ADDR_EXT |=> st.ext == $past(reg_wdata[EXT_W-1:0]);
    endproperty
    a_ext_write: assert property (p_ext_write) else $error("extended control write lost"); // see [R10] see [R14]

    property p_read_stands;
        !reg_rd |=> reg_rdata == 8'h00;
    endproperty
    a_read_stands: assert property (p_read_stands) else $error("read data outlive their cycle"); // see [R16]

    property p_mask_release;
        bus_ok && reg_wr && reg_addr == ADDR_MASK && reg_wdata[STAT_W-1:0] == '0 |=> !irq_n_oe;
    endproperty
    a_mask_release: assert property (p_mask_release) else $error("pin not released after mask cleared"); // see [R17]

    // Supply and wipe checks.
    property p_irq_trip;
        !st.vcc_s1 |=> !irq_n_oe;
    endproperty
    a_irq_trip: assert property (p_irq_trip) else $error("interrupt pin driven below trip"); // see [R16]

    property p_wipe_backup;
        wipe_req && !st.vcc_s2 |=> wiping;
    endproperty
    a_wipe_backup: assert property (p_wipe_backup) else $error("wipe stalled on backup power"); // see [R5]
endmodule
`default_nettype wire

// [hw/rtcp_pkg.sv]
// Shared constants for the clock output and pin control block.
package rtcp_pkg;
    // Core clock rate and the recovery delay after primary supply returns.
    localparam int unsigned CLK_MHZ = 125;
    localparam int unsigned REC_TIME_US = 20;
    localparam int unsigned REC_CYCLES = REC_TIME_US * CLK_MHZ;
    localparam int unsigned REC_W = $clog2(REC_CYCLES);

    // User RAM size and the value a wipe writes.
    localparam int unsigned RAM_BYTES = 242;
    localparam logic [7:0] RAM_FILL = 8'hff;

    // Divider geometry.
    localparam int unsigned DIV_STAGES = 15;
    localparam int unsigned RATE_W = 4;

    // Register offsets on the plain register port.
    localparam logic [7:0] ADDR_CTRL_A = 8'h00;
    localparam logic [7:0] ADDR_CTRL_B = 8'h01;
    localparam logic [7:0] ADDR_EXT = 8'h02;
    localparam logic [7:0] ADDR_STAT = 8'h03;
    localparam logic [7:0] ADDR_MASK = 8'h04;
    localparam logic [7:0] ADDR_RAM_BASE = 8'h0e;

    // Control A fields: rate in the low nibble, divider control above it.
    localparam int unsigned CA_RATE_LSB = 0;
    localparam int unsigned CA_DV1_BIT = 5;
    localparam int unsigned CA_W = 7;
    // Control B field.
    localparam int unsigned CB_SQUARE_WAVE_EN_BIT = 3;
    // Extended control fields.
    localparam int unsigned EXT_OSC_EN_BIT = 0;
    localparam int unsigned EXT_ABE_BIT = 1;
    localparam int unsigned EXT_FORCE_32K_EN_BIT = 2;
    localparam int unsigned EXT_WIPE_EN_BIT = 3;
    localparam int unsigned EXT_W = 4;
    // Status and mask fields.
    localparam int unsigned ST_WIPE_DONE = 0;
    localparam int unsigned ST_PWR_FAIL = 1;
    localparam int unsigned ST_PWR_UP = 2;
    localparam int unsigned ST_EXT_EVT = 3;
    localparam int unsigned STAT_W = 4;
endpackage

// [hw/rtcp_ram_if.sv]
// Access path between the register port and the user RAM.
`timescale 1ns/1ps
`default_nettype none
interface rtcp_ram_if;
    logic wr;
    logic [7:0] idx;
    logic [7:0] wdata;
    logic [7:0] rdata;
    modport host (output wr, output idx, output wdata, input rdata);
    modport ram (input wr, input idx, input wdata, output rdata);
endinterface
`default_nettype wire

// [hw/rtcp_sqw.sv]
// Timebase divider and square-wave source selection.
`timescale 1ns/1ps
`default_nettype none
module rtcp_sqw #(
    parameter int unsigned STAGES = rtcp_pkg::DIV_STAGES
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Oscillator pin
    input wire logic osc_in,
    // Controls
    input wire logic osc_en,
    input wire logic div_run,
    input wire logic force_32k_en,
    input wire logic square_wave_en,
    input wire logic [rtcp_pkg::RATE_W-1:0] rate,
    // Results
    output logic wave,
    output logic div_active
);
    import rtcp_pkg::*;

    typedef struct packed {
        logic osc_s1;
        logic osc_s2;
        logic osc_prev;
        logic [STAGES-1:0] div;
        logic wave;
        logic active;
    } rtcp_sqw_s;

    rtcp_sqw_s st;
    rtcp_sqw_s nx;
    logic [3:0] tap;

    ////////////////////////////////////////////////////////////////////////////
    // Rate one and two reuse the 256 Hz and 128 Hz taps, so 13 taps serve 15 codes.
    always_comb begin
        nx = st;
        nx.osc_s1 = osc_in;
        nx.osc_s2 = st.osc_s1;
        nx.osc_prev = st.osc_s2;
        nx.active = osc_en && div_run;
        tap = 4'h0;
        if (rate == 4'h1) begin
            tap = 4'h6;
        end else if (rate == 4'h2) begin
            tap = 4'h7;
        end else if (rate != 4'h0) begin
            tap = rate - 4'h2;
        end
        // The timebase counts rising edges of the 32.768 kHz pin.  see [R15] see [R14]
        if (nx.active && st.osc_s2 && !st.osc_prev) begin
            nx.div = st.div + 1'b1;
        end
        if (osc_en && force_32k_en) begin
            nx.wave = st.osc_s2; // see [R8]
        end else if (square_wave_en && rate != 4'h0 && nx.active) begin
            nx.wave = st.div[tap]; // see [R9] see [R7]
        end else begin
            nx.wave = 1'b0; // see [R7]
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= nx;
        end
    end

    assign wave = st.wave;
    assign div_active = st.active;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    property p_force_32k;
        osc_en && force_32k_en |=> wave == $past(st.osc_s2);
    endproperty
    a_force_32k: assert property (p_force_32k) else $error("forced 32k wave does not follow oscillator"); // see [R8]
endmodule
`default_nettype wire

// [hw/rtcp_wipe.sv]
// User RAM with the hardware wipe sequencer.
`timescale 1ns/1ps
`default_nettype none
module rtcp_wipe #(
    parameter int unsigned BYTES = rtcp_pkg::RAM_BYTES
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Host access
    rtcp_ram_if.ram bus,
    // Wipe control
    input wire logic wipe_req,
    output logic wipe_done,
    output logic wiping
);
    import rtcp_pkg::*;

    typedef struct packed {
        logic [7:0] ptr;
        logic active;
        logic done;
    } rtcp_wipe_s;

    rtcp_wipe_s st;
    rtcp_wipe_s nx;
    logic [7:0] mem [BYTES];

    ////////////////////////////////////////////////////////////////////////////
    // The sweep repeats while the pin is held, so a long press leaves every byte set.
    always_comb begin
        nx = st;
        nx.done = 1'b0;
        if (wipe_req) begin
            nx.active = 1'b1;
            if (st.active) begin
                if (st.ptr == 8'(BYTES - 1)) begin
                    nx.ptr = 8'h00;
                    nx.done = 1'b1;
                end else begin
                    nx.ptr = st.ptr + 8'h01;
                end
            end
        end else begin
            nx.active = 1'b0;
            nx.ptr = 8'h00;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= nx;
        end
    end

    // The wipe owns the write port; a host write during a sweep is dropped.
    always_ff @(posedge core_clk) begin
        if (st.active && wipe_req) begin
            mem[st.ptr] <= RAM_FILL; // see [R4] see [R5]
        end else if (bus.wr && bus.idx < 8'(BYTES)) begin
            mem[bus.idx] <= bus.wdata;
        end
    end

    assign bus.rdata = (bus.idx < 8'(BYTES)) ? mem[bus.idx] : 8'h00;
    assign wipe_done = st.done;
    assign wiping = st.active;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    property p_wipe_fill;
        st.active && wipe_req |=> mem[$past(st.ptr)] == RAM_FILL;
    endproperty
    a_wipe_fill: assert property (p_wipe_fill) else $error("wiped byte is not all ones"); // see [R4]
endmodule
`default_nettype wire

// [tb/rtcp_host_model.sv]
// Host side model: pulled-up interrupt line, wipe switch and timebase source.
`timescale 1ns/1ps
`default_nettype none
module rtcp_host_model (
    // Interrupt pin from the device
    input wire logic irq_n_o,
    input wire logic irq_n_oe,
    // Wipe switch and resolved lines
    input wire logic wipe_press,
    output logic irq_line,
    output logic ram_wipe_n,
    output logic osc_in
);
    ////////////////////////////////////////
    // The host pull-up makes the released pin read high; the host clears flags to release it.
    assign irq_line = irq_n_oe ? irq_n_o : 1'b1;
    // A closed switch shorts the pin; otherwise the internal pull-up holds it high.
    assign ram_wipe_n = wipe_press ? 1'b0 : 1'b1;
    // Free running source; the half period is rounded to whole nanoseconds.
    initial begin
        osc_in = 1'b0;
        forever #15259 osc_in = ~osc_in;
    end
endmodule
`default_nettype wire

// [tb/tb.sv]
// Self-checking bench for the clock output and pin control block.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import rtcp_pkg::*;
    logic core_clk, rst, reg_wr, reg_rd, vcc_ok, aux_supply, ext_event, wipe_press;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic osc_in, ram_wipe_n, irq_n_o, irq_n_oe, square_wave_out, irq_line;
    logic rd_seen = 1'b0;
    logic [7:0] exp_q[$];
    logic [7:0] ram_addr[6];
    logic [31:0] seed;
    int err_count = 0;
    int n_tests = 0;
    int cyc = 0;
    int tog;

    ////////////////////////////////////////
    // Device and host side.
    rtcp_top dut (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .vcc_ok(vcc_ok),
        .aux_supply(aux_supply), .osc_in(osc_in), .ram_wipe_n(ram_wipe_n), .irq_n_o(irq_n_o),
        .irq_n_oe(irq_n_oe), .square_wave_out(square_wave_out), .ext_event(ext_event));
    rtcp_host_model host (.irq_n_o(irq_n_o), .irq_n_oe(irq_n_oe), .wipe_press(wipe_press),
        .irq_line(irq_line), .ram_wipe_n(ram_wipe_n), .osc_in(osc_in));

    ////////////////////////////////////////
    // Clock and a cycle ceiling well above the roughly 62000 cycles the run needs.
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 80000) begin
            err_count++;
            final_report();
        end
    end

    ////////////////////////////////////////
    // Comparison, verdict and random source.
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    ////////////////////////////////////////
    // Register port cycles; a read leaves its expected byte in the queue.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        exp_q.push_back(e);
        @(posedge core_clk);
        reg_rd <= 1'b0;
    endtask
    task automatic pulse_event();
        @(posedge core_clk);
        ext_event <= 1'b1;
        @(posedge core_clk);
        ext_event <= 1'b0;
    endtask
    // Settle first so a switch-off edge from the last write is not counted.
    task automatic wave_check(input int n, input int lo, input int hi);
        logic prev;
        repeat (20) @(posedge core_clk);
        tog = 0;
        prev = square_wave_out;
        repeat (n) begin
            @(posedge core_clk);
            if (square_wave_out !== prev) tog++;
            prev = square_wave_out;
        end
        check("square wave toggles", {7'h0, tog inside {[lo:hi]}}, 8'h01);
    endtask
    task automatic irq_is(input logic lvl);
        #1;
        check("interrupt line", {7'h0, irq_line}, {7'h0, lvl});
    endtask

    ////////////////////////////////////////
    // Read data stand only in the cycle after the strobe, so they are taken there.
    always @(posedge core_clk) begin
        if (rd_seen) check("read data", reg_rdata, exp_q.pop_front());
        rd_seen <= reg_rd;
    end

    ////////////////////////////////////////
    // Main sequence.
    initial begin
        rst = 1'b1;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        vcc_ok = 1'b0;
        aux_supply = 1'b1;
        ext_event = 1'b0;
        wipe_press = 1'b0;
        seed = 32'd79459;
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        // Supply below trip: writes dropped, reads empty, pin released.
        wr(ADDR_MASK, 8'h0f);
        rd(ADDR_MASK, 8'h00);
        irq_is(1'b1);
        @(posedge core_clk);
        vcc_ok <= 1'b1;
        repeat (100) @(posedge core_clk);
        rd(ADDR_EXT, 8'h00);
        repeat (REC_CYCLES) @(posedge core_clk);
        rd(ADDR_STAT, 8'h04);
        rd(ADDR_EXT, 8'h15);
        wave_check(8000, 3, 5);
        // Interrupt set, clear, mask and unmask; the clear is taken at the edge that ends the write.
        wr(ADDR_MASK, 8'h08);
        pulse_event();
        irq_is(1'b0);
        wr(ADDR_STAT, 8'h08);
        irq_is(1'b1);
        @(posedge core_clk);
        irq_is(1'b1);
        wr(ADDR_MASK, 8'h00);
        pulse_event();
        @(posedge core_clk);
        irq_is(1'b1);
        wr(ADDR_MASK, 8'h08);
        @(posedge core_clk);
        irq_is(1'b0);
        wr(ADDR_MASK, 8'h00);
        @(posedge core_clk);
        irq_is(1'b1);
        rd(ADDR_STAT, 8'h0c);
        wr(ADDR_STAT, 8'h0c);
        rd(ADDR_STAT, 8'h00);
        // Square-wave source selection.
        wr(ADDR_EXT, 8'h01);
        wr(ADDR_CTRL_B, 8'h00);
        wave_check(4000, 0, 0);
        wr(ADDR_CTRL_A, 8'h2f);
        wr(ADDR_EXT, 8'h05);
        wave_check(8000, 3, 5);
        wr(ADDR_EXT, 8'h04);
        wave_check(4000, 0, 0);
        wr(ADDR_EXT, 8'h01);
        wr(ADDR_CTRL_A, 8'h23);
        wr(ADDR_CTRL_B, 8'h08);
        wave_check(16000, 1, 3);
        wr(ADDR_CTRL_A, 8'h20);
        wave_check(4000, 0, 0);
        // User RAM at both window ends and random places, plus an unmapped address.
        for (int i = 0; i < 6; i++) begin
            seed = xs(seed);
            ram_addr[i] = (i == 0) ? ADDR_RAM_BASE : (i == 1) ? 8'hff : ADDR_RAM_BASE + 8'(seed % RAM_BYTES);
            wr(ram_addr[i], seed[15:8] & 8'h7f);
            rd(ram_addr[i], seed[15:8] & 8'h7f);
        end
        wr(8'h07, 8'h5a);
        rd(8'h07, 8'h00);
        // Supply loss with the aux supply unused, and a wipe on backup power.
        wr(ADDR_MASK, 8'h08);
        pulse_event();
        wr(ADDR_EXT, 8'h0d);
        @(posedge core_clk);
        aux_supply <= 1'b0;
        vcc_ok <= 1'b0;
        repeat (10) @(posedge core_clk);
        irq_is(1'b1);
        rd(ADDR_MASK, 8'h00);
        wave_check(4000, 0, 0);
        wipe_press <= 1'b1;
        repeat (300) @(posedge core_clk);
        wipe_press <= 1'b0;
        repeat (10) @(posedge core_clk);
        vcc_ok <= 1'b1;
        aux_supply <= 1'b1;
        repeat (REC_CYCLES + 20) @(posedge core_clk);
        for (int i = 0; i < 6; i++) rd(ram_addr[i], RAM_FILL);
        rd(ADDR_STAT, 8'h0f);
        irq_is(1'b0);
        // Supply loss with aux enable and aux supply: forced 32k keeps running.
        wr(ADDR_EXT, 8'h07);
        @(posedge core_clk);
        vcc_ok <= 1'b0;
        wave_check(8000, 3, 5);
        repeat (4) @(posedge core_clk);
        final_report();
    end
endmodule
`default_nettype wire
